//--- core/bdm_pkg.sv
// bus driver mode control: shared constants, types and decode functions
// assumes a single 40 MHz clock and APB register access
package bdm_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS   = 25;
  localparam int RX_MIN_BIT_NS   = 60;
  // minimum bit time in cycles, rounded down, never below one cycle
  localparam int RX_FILT_CYC     = (RX_MIN_BIT_NS / CLK_PERIOD_NS) < 1 ?
                                   1 : (RX_MIN_BIT_NS / CLK_PERIOD_NS);
  localparam int MODE_STABLE_CYC = 4;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  WAKE_CLR_OFS   = 8'h08;
  localparam int          CTRL_INH_BIT   = 0;
  localparam logic        CTRL_INH_RST   = 1'b0;
  localparam int          WAKE_CLR_BIT   = 0;
  localparam int          ST_MODE_LSB    = 0;
  localparam int          ST_WAKE_BIT    = 3;
  localparam int          ST_TXON_BIT    = 4;
  localparam int          ST_BIAS_LSB    = 5;
  localparam int          ST_SYM_LSB     = 7;
  localparam int          ST_SUP_LSB     = 9;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [2:0] {
    BDM_NORMAL      = 3'b000,
    BDM_LISTEN      = 3'b001,
    BDM_STANDBY     = 3'b010,
    BDM_SLEEP_ENTRY = 3'b011,
    BDM_SLEEP       = 3'b100,
    BDM_UNPOWERED   = 3'b101
  } bdm_mode_t;

  typedef enum logic [1:0] {
    BDM_SYM_IDLE = 2'b00,
    BDM_SYM_D0   = 2'b01,
    BDM_SYM_D1   = 2'b10
  } bdm_sym_t;

  typedef enum logic [1:0] {
    BDM_BIAS_OPEN = 2'b00,
    BDM_BIAS_GND  = 2'b01,
    BDM_BIAS_VOLT = 2'b10
  } bdm_bias_t;

  typedef struct packed {
    logic txd;
    logic transmit_enable_n;
    logic guardian_enable;
    logic standby_select_n;
    logic mode_enable;
  } bdm_pins_t;

  typedef struct packed {
    logic vcc_ok;
    logic vbat_ok;
    logic io_ok;
  } bdm_supply_t;

  typedef struct packed {
    logic      tx_enable;
    logic      tx_level;
    bdm_bias_t bias;
    logic      pull_enable;
  } bdm_drv_t;

  // levels taken by floating inputs
  localparam bdm_pins_t PIN_DEFAULTS = '{txd: 1'b0, transmit_enable_n: 1'b1,
    guardian_enable: 1'b0, standby_select_n: 1'b0, mode_enable: 1'b0};

  // ********************************************************************
  // decode functions
  // ********************************************************************
  function automatic bdm_mode_t bdm_cmd_mode(input logic [1:0] stb_en);
    case (stb_en)
      2'b11:   return BDM_NORMAL;
      2'b10:   return BDM_LISTEN;
      2'b01:   return BDM_SLEEP_ENTRY;
      default: return BDM_STANDBY;
    endcase
  endfunction : bdm_cmd_mode

  function automatic bdm_bias_t bdm_mode_bias(input bdm_mode_t m);
    case (m)
      BDM_NORMAL, BDM_LISTEN: return BDM_BIAS_VOLT;
      BDM_UNPOWERED:          return BDM_BIAS_OPEN;
      default:                return BDM_BIAS_GND;
    endcase
  endfunction : bdm_mode_bias

  function automatic logic bdm_low_power(input bdm_mode_t m);
    return (m == BDM_STANDBY) || (m == BDM_SLEEP) || (m == BDM_SLEEP_ENTRY);
  endfunction : bdm_low_power

endpackage : bdm_pkg

//--- core/bdm_filter.sv
// bdm_filter: passes a word only after it held for STABLE samples
// assumes din is synchronous to pclk
module bdm_filter #(
  parameter int         WIDTH  = 2,
  parameter int         STABLE = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  localparam int CW = $clog2(STABLE + 1);

  if (STABLE < 1 || WIDTH < 1) begin : g_bad_param
    $error("bdm_filter: STABLE and WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] smp_q;
  logic [WIDTH-1:0] dout_q;
  logic [CW-1:0]    cnt_q;
  // cnt_q is the run length of the value in smp_q, saturating at STABLE;
  // a word seen on exactly STABLE samples passes, a shorter run does not
  wire              same = (din == smp_q);
  wire              done = (cnt_q >= CW'(STABLE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q  <= RST_VAL;
      dout_q <= RST_VAL;
      cnt_q  <= CW'(STABLE);
    end else begin
      smp_q <= din;
      if (!same) begin
        cnt_q <= CW'(1);
      end else if (!done) begin
        cnt_q <= cnt_q + CW'(1);
      end
      if (done) begin
        dout_q <= smp_q;
      end
    end
  end

  assign dout = dout_q;

endmodule : bdm_filter

//--- core/bdm_core.sv
// bdm_core: mode state machine and data-path gating of a bus driver
// assumes pin inputs are synchronous to pclk and an APB master
//
// Overview of operation
// - bus symbols Data_0, Data_1, Idle; transmitter off during Idle.
// - six modes; sleep is reached only through the sleep-entry state.
// - mode changes only on host command, supply change, wake event or sleep-entry expiry.
// - standby and sleep are low-power; normal and listen-only are not.
// - floating transmit-enable or guardian-enable keeps transmitter off.
// - floating transmit data with transmitter active drives Data_0.
// - unconnected mode-select inputs read low, giving standby.
// - floating defaults: txd low, enable_n high, others low.
// - outside normal, transmit inputs ignored and pull structures off.
// - missing supply forces the fail-safe mode.
// - transmitter active only in normal mode.
// - receiver decodes symbols in normal and listen-only modes.
// - received bits of 60 ns or longer pass the input filter.
// - activity goes to guardian side, data bits to controller side.
// - bias voltage, ground or open depending on mode.
// - standby-select and mode-enable pick the mode per the command table.
// - transmission starts only with txd low; txd then picks Data_1/0.
// - activity and data outputs per mode; wake flag in low power.
module bdm_core
  import bdm_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // controller, guardian and host pins; conn bit low means floating
  input  wire bdm_pkg::bdm_pins_t   pins_in,
  input  wire bdm_pkg::bdm_pins_t   pins_conn,
  output logic                      rx_data,
  output logic                      bus_activity_n,
  // supplies and wake sources
  input  wire bdm_pkg::bdm_supply_t supply,
  input  wire logic                 bus_wake,
  input  wire logic                 local_wake,
  // bus side
  input  wire bdm_pkg::bdm_sym_t    bus_sym_raw,
  output bdm_pkg::bdm_drv_t         drv,
  output bdm_pkg::bdm_mode_t        mode
);

  import bdm_pkg::*;

  // ********************************************************************
  // input defaults
  // ********************************************************************
  // with the io reference gone every pin input falls back to its default
  wire       io_ok  = supply.io_ok;
  wire bdm_pins_t eff = io_ok ? ((pins_in & pins_conn) |
                        (PIN_DEFAULTS & ~pins_conn)) : PIN_DEFAULTS;

  // ********************************************************************
  // mode-select and receive filters
  // ********************************************************************
  logic [1:0] cmd_filt;
  logic [1:0] rx_filt;

  bdm_filter #(
    .WIDTH   (2),
    .STABLE  (MODE_STABLE_CYC),
    .RST_VAL (2'b00)
  ) u_cmd_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({eff.standby_select_n, eff.mode_enable}),
    .dout    (cmd_filt)
  );

  bdm_filter #(
    .WIDTH   (2),
    .STABLE  (RX_FILT_CYC),
    .RST_VAL (2'b00)
  ) u_rx_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (bus_sym_raw),
    .dout    (rx_filt)
  );

  wire bdm_sym_t rx_sym = bdm_sym_t'(rx_filt);

  // ********************************************************************
  // mode state machine
  // ********************************************************************
  bdm_mode_t  mode_q;
  bdm_mode_t  mode_d;
  logic [1:0] cmd_prev_q;
  logic       wake_q;
  logic       inhibit_q;
  logic       tx_on_q;

  wire all_off  = ~supply.vcc_ok & ~supply.vbat_ok & ~io_ok;
  wire uv_any   = ~(&supply);
  wire cmd_chg  = (cmd_filt != cmd_prev_q);
  wire wake_evt = (bus_wake | local_wake) & bdm_low_power(mode_q);
  wire bdm_mode_t cmd_mode = bdm_cmd_mode(cmd_filt);

  // only supplies, host commands, wake events and the automatic sleep-entry to sleep step move the mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      BDM_UNPOWERED: begin
        if (!uv_any) begin
          mode_d = BDM_STANDBY;
        end
      end
      BDM_NORMAL, BDM_LISTEN, BDM_STANDBY, BDM_SLEEP_ENTRY,
      BDM_SLEEP: begin
        if (all_off) begin
          mode_d = BDM_UNPOWERED;
        end else if (uv_any) begin
          mode_d = BDM_STANDBY;
        end else if (wake_evt && mode_q == BDM_SLEEP) begin
          mode_d = BDM_STANDBY;
        end else if (cmd_chg) begin
          // a pending wake keeps the device out of sleep
          mode_d = (cmd_mode == BDM_SLEEP_ENTRY && wake_q) ?
                   BDM_STANDBY : cmd_mode;
        end else if (mode_q == BDM_SLEEP_ENTRY) begin
          mode_d = BDM_SLEEP;
        end
      end
      default: mode_d = BDM_STANDBY;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= BDM_STANDBY;
      cmd_prev_q <= 2'b00;
    end else begin
      mode_q     <= mode_d;
      cmd_prev_q <= cmd_filt;
    end
  end

  // ********************************************************************
  // wake flag
  // ********************************************************************
  wire wr_en    = psel & penable & pwrite;
  wire wake_clr = wr_en && paddr == WAKE_CLR_OFS && pwdata[WAKE_CLR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (wake_evt) begin
      wake_q <= 1'b1; // set wins over a clear in the same cycle
    end else if (wake_clr) begin
      wake_q <= 1'b0;
    end
  end

  // ********************************************************************
  // transmitter gating
  // ********************************************************************
  // inputs only count in normal mode; elsewhere they are blocked
  wire tx_req = (mode_q == BDM_NORMAL) & ~eff.transmit_enable_n
              & eff.guardian_enable & ~inhibit_q;
  // never start with Data_1: turn-on waits for txd low
  wire tx_on_d = tx_req & (tx_on_q | ~eff.txd);

  bdm_drv_t drv_q;
  logic     rx_data_q;
  logic     act_n_q;
  wire      non_lp = (mode_q == BDM_NORMAL) || (mode_q == BDM_LISTEN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_on_q   <= 1'b0;
      drv_q     <= '{tx_enable: 1'b0, tx_level: 1'b0,
                     bias: BDM_BIAS_GND, pull_enable: 1'b0};
      // reset mode is standby with no wake flag, so both outputs idle high
      rx_data_q <= 1'b1;
      act_n_q   <= 1'b1;
    end else begin
      tx_on_q           <= tx_on_d;
      drv_q.tx_enable   <= tx_on_d;
      drv_q.tx_level    <= tx_on_d & eff.txd;
      drv_q.bias        <= bdm_mode_bias(mode_q);
      drv_q.pull_enable <= (mode_q == BDM_NORMAL);
      if (!io_ok) begin
        rx_data_q <= 1'b0;
        act_n_q   <= 1'b0;
      end else if (non_lp) begin
        rx_data_q <= (rx_sym != BDM_SYM_D0);
        act_n_q   <= (rx_sym == BDM_SYM_IDLE);
      end else begin
        rx_data_q <= ~wake_q;
        act_n_q   <= ~wake_q;
      end
    end
  end

  assign drv            = drv_q;
  assign rx_data        = rx_data_q;
  assign bus_activity_n = act_n_q;
  assign mode           = mode_q;

  // ********************************************************************
  // apb registers
  // ********************************************************************
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_st   = (paddr == STATUS_OFS);
  wire hit_wk   = (paddr == WAKE_CLR_OFS);
  wire hit      = hit_ctrl | hit_st | hit_wk;
  wire setup    = psel & ~penable;

  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_MODE_LSB +: 3] = mode_q;
    status_w[ST_WAKE_BIT]      = wake_q;
    status_w[ST_TXON_BIT]      = tx_on_q;
    status_w[ST_BIAS_LSB +: 2] = drv_q.bias;
    status_w[ST_SYM_LSB +: 2]  = rx_sym;
    status_w[ST_SUP_LSB +: 3]  = supply;
  end

  wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, inhibit_q} :
                       hit_st   ? status_w :
                       hit_wk   ? {31'h0000_0000, wake_q} : 32'h0000_0000;

  // read data is caught in the setup cycle so prdata comes from a flop
  logic [31:0] prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      inhibit_q <= CTRL_INH_RST;
    end else begin
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_en && hit_ctrl) begin
        inhibit_q <= pwdata[CTRL_INH_BIT];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit;

  // ********************************************************************
  // assertions
  // ********************************************************************
  sequence s_enter_sleep_entry;
    mode_q == BDM_SLEEP_ENTRY && !uv_any && !cmd_chg;
  endsequence

  sequence s_reach_sleep;
    mode_q == BDM_SLEEP;
  endsequence

  property p_tx_only_normal;
    @(posedge pclk) disable iff (!presetn)
    drv.tx_enable |-> $past(mode_q) == BDM_NORMAL;
  endproperty
  a_tx_only_normal: assert property (p_tx_only_normal)
    else $error("transmitter active outside normal mode");

  property p_tx_start_low;
    @(posedge pclk) disable iff (!presetn)
    $rose(tx_on_q) |-> !$past(eff.txd) && !drv.tx_level;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low)
    else $error("transmission started with Data_1");

  property p_guard_off;
    @(posedge pclk) disable iff (!presetn)
    (!eff.guardian_enable || eff.transmit_enable_n) |=> !drv.tx_enable;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("transmitter on without both enables");

  property p_bias;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> drv.bias == bdm_mode_bias($past(mode_q));
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias does not follow mode");

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
    s_enter_sleep_entry |=> s_reach_sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry did not move to sleep");

  property p_failsafe;
    @(posedge pclk) disable iff (!presetn)
    uv_any && !all_off && mode_q != BDM_UNPOWERED |=> mode_q == BDM_STANDBY;
  endproperty
  a_failsafe: assert property (p_failsafe)
    else $error("missing supply did not force standby");

  property p_lp_outputs;
    @(posedge pclk) disable iff (!presetn)
    bdm_low_power(mode_q) && io_ok |=>
      rx_data == !$past(wake_q) && bus_activity_n == rx_data;
  endproperty
  a_lp_outputs: assert property (p_lp_outputs)
    else $error("low-power outputs do not show wake flag");

  property p_wake_set;
    @(posedge pclk) disable iff (!presetn)
    wake_evt |=> wake_q ##1 (wake_q || $past(wake_clr));
  endproperty
  a_wake_set: assert property (p_wake_set)
    else $error("wake event lost");

endmodule : bdm_core

//--- tb/bdm_bus_model.sv
// bdm_bus_model: differential bus seen as a symbol stream
// assumes drv comes from bdm_core and remote_sym from the bench
module bdm_bus_model
  import bdm_pkg::*;
(
  // clock
  input  wire logic               pclk,
  // local driver and remote node
  input  wire bdm_pkg::bdm_drv_t  drv,
  input  wire bdm_pkg::bdm_sym_t  remote_sym,
  // bus symbol back to the receiver
  output bdm_pkg::bdm_sym_t       bus_sym
);
  timeunit 1ns;
  timeprecision 1ps;

  initial bus_sym = BDM_SYM_IDLE;

  // own transmitter wins; otherwise the remote node or idle
  always @(posedge pclk) begin
    if (drv.tx_enable) begin
      bus_sym <= drv.tx_level ? BDM_SYM_D1 : BDM_SYM_D0;
    end else begin
      bus_sym <= remote_sym;
    end
  end
endmodule : bdm_bus_model

//--- tb/bus_driver_mode_control_tb_top.sv
// testbench for bdm_core: pin sequences, apb access, bus loopback
// assumes bdm_core and bdm_bus_model, assertions live in the design
module bus_driver_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bdm_pkg::*;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  bdm_pins_t         pins_in = '0;
  bdm_pins_t         pins_conn = '0;
  logic              rx_data;
  logic              bus_activity_n;
  bdm_supply_t       supply = 3'b111;
  logic              bus_wake = 1'b0;
  logic              local_wake = 1'b0;
  bdm_sym_t          bus_sym_raw;
  bdm_sym_t          remote_sym = BDM_SYM_IDLE;
  bdm_drv_t          drv;
  bdm_mode_t         mode;
  logic [31:0]       rd;
  logic              err;
  logic              low_seen;
  int                bad_count = 0;
  int                checks = 0;

  always #12.5 pclk = ~pclk;

  bdm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_conn(pins_conn), .rx_data(rx_data),
    .bus_activity_n(bus_activity_n), .supply(supply),
    .bus_wake(bus_wake), .local_wake(local_wake),
    .bus_sym_raw(bus_sym_raw), .drv(drv), .mode(mode));

  bdm_bus_model bus (.pclk(pclk), .drv(drv), .remote_sym(remote_sym),
    .bus_sym(bus_sym_raw));

  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // one apb transfer; the answer is awaited, never assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  task automatic wait_mode(input bdm_mode_t m);
    int n;
    for (n = 0; n < 30 && mode !== m; n++) settle(1);
    `CHK(mode, m)
    if (mode !== m) print_verdict();
  endtask : wait_mode

  task automatic set_pins(input logic [4:0] v);
    @(posedge pclk);
    pins_in <= bdm_pins_t'(v);
  endtask : set_pins

  task automatic rx_chk(input bdm_sym_t s, input logic rxd, input logic an);
    @(posedge pclk);
    remote_sym <= s;
    settle(8);
    `CHK({rx_data, bus_activity_n}, {rxd, an})
  endtask : rx_chk

  // ********************************************************************
  // sequence; pin bits are txd, enable_n, guardian, standby_sel, mode_en
  // ********************************************************************
  initial begin
    settle(1);
    `CHK(mode, BDM_STANDBY)
    `CHK(drv.bias, BDM_BIAS_GND)
    @(posedge pclk);
    presetn <= 1'b1;
    settle(10);
    `CHK(mode, BDM_STANDBY)
    `CHK({rx_data, bus_activity_n}, 2'b11)
    apb(1'b0, CTRL_OFS, '0);
    `CHK(rd[CTRL_INH_BIT], CTRL_INH_RST)
    pins_conn <= 5'h1F;
    set_pins(5'b01011);
    wait_mode(BDM_NORMAL);
    settle(1);
    `CHK({drv.bias, drv.pull_enable}, {BDM_BIAS_VOLT, 1'b1})
    `CHK(drv.tx_enable, 1'b0)
    set_pins(5'b10111);
    settle(4);
    `CHK(drv.tx_enable, 1'b0)
    set_pins(5'b00111);
    settle(3);
    `CHK({drv.tx_enable, drv.tx_level}, 2'b10)
    set_pins(5'b10111);
    settle(8);
    `CHK({drv.tx_enable, drv.tx_level}, 2'b11)
    `CHK({rx_data, bus_activity_n}, 2'b10)
    apb(1'b0, STATUS_OFS, '0);
    `CHK(rd[ST_TXON_BIT], 1'b1)
    `CHK(rd[ST_MODE_LSB +: 3], BDM_NORMAL)
    pins_conn <= 5'h0F;
    settle(3);
    `CHK({drv.tx_enable, drv.tx_level}, 2'b10)
    @(posedge pclk);
    pins_conn <= 5'h1B;
    settle(3);
    `CHK(drv.tx_enable, 1'b0)
    @(posedge pclk);
    pins_conn <= 5'h1F;
    set_pins(5'b00111);
    settle(3);
    // inhibit from software overrides an otherwise legal transmit
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    settle(2);
    `CHK(drv.tx_enable, 1'b0)
    apb(1'b0, CTRL_OFS, '0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, CTRL_OFS, '0);
    set_pins(5'b00110);
    wait_mode(BDM_LISTEN);
    settle(2);
    `CHK({drv.tx_enable, drv.pull_enable}, 2'b00)
    `CHK(drv.bias, BDM_BIAS_VOLT)
    rx_chk(BDM_SYM_D0, 1'b0, 1'b0);
    rx_chk(BDM_SYM_D1, 1'b1, 1'b0);
    rx_chk(BDM_SYM_IDLE, 1'b1, 1'b1);
    // a one-cycle spike must not pass, a bit seen on two samples must
    @(posedge pclk);
    remote_sym <= BDM_SYM_D0;
    @(posedge pclk);
    remote_sym <= BDM_SYM_IDLE;
    repeat (8) begin
      settle(1);
      `CHK({rx_data, bus_activity_n}, 2'b11)
    end
    @(posedge pclk);
    remote_sym <= BDM_SYM_D0;
    repeat (2) @(posedge pclk);
    remote_sym <= BDM_SYM_IDLE;
    low_seen = 1'b0;
    repeat (8) begin
      settle(1);
      low_seen = low_seen | ~rx_data;
    end
    `CHK(low_seen, 1'b1)
    set_pins(5'b00001);
    wait_mode(BDM_SLEEP);
    settle(6);
    `CHK({drv.bias, drv.tx_enable}, {BDM_BIAS_GND, 1'b0})
    `CHK({rx_data, bus_activity_n}, 2'b11)
    @(posedge pclk);
    local_wake <= 1'b1;
    @(posedge pclk);
    local_wake <= 1'b0;
    wait_mode(BDM_STANDBY);
    settle(6);
    `CHK({rx_data, bus_activity_n}, 2'b00)
    apb(1'b1, WAKE_CLR_OFS, 32'h0000_0001);
    apb(1'b0, WAKE_CLR_OFS, '0);
    `CHK(rd[WAKE_CLR_BIT], 1'b0)
    @(posedge pclk);
    bus_wake <= 1'b1;
    @(posedge pclk);
    bus_wake <= 1'b0;
    apb(1'b0, STATUS_OFS, '0);
    `CHK(rd[ST_WAKE_BIT], 1'b1)
    apb(1'b1, WAKE_CLR_OFS, 32'h0000_0001);
    set_pins(5'b00000);
    settle(10);
    set_pins(5'b00011);
    set_pins(5'b00000);
    // a glitch that got through would show normal for a while
    repeat (14) begin
      settle(1);
      `CHK(mode, BDM_STANDBY)
    end
    apb(1'b0, 8'h0C, '0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    set_pins(5'b00011);
    wait_mode(BDM_NORMAL);
    @(posedge pclk);
    supply <= 3'b011;
    wait_mode(BDM_STANDBY);
    @(posedge pclk);
    supply <= 3'b000;
    wait_mode(BDM_UNPOWERED);
    settle(2);
    `CHK({drv.bias, drv.tx_enable}, {BDM_BIAS_OPEN, 1'b0})
    `CHK({rx_data, bus_activity_n}, 2'b00)
    @(posedge pclk);
    supply <= 3'b111;
    wait_mode(BDM_STANDBY);
    print_verdict();
  end
endmodule : bus_driver_mode_control_tb_top
